// ==== hdl/sdram_cmd_dev.sv ====
// memory end: command decode, bank state, mode registers, burst start
`timescale 1ns/1ps
module sdram_cmd_dev
(
	input wire logic clk,
	input wire logic rst_b,
	sdram_link_if.device link,
	output logic [sdram_pkg::bank_count-1:0] bank_open,
	output logic [11:0] mode_reg,
	output logic [11:0] ext_mode_reg,
	output logic burst_start,
	output logic burst_write,
	output logic [1:0] burst_bank,
	output logic [sdram_pkg::row_w-1:0] burst_row,
	output logic [sdram_pkg::col_w-1:0] burst_col,
	output logic burst_auto_precharge,
	output logic bad_cmd
);
	import sdram_pkg::*;

	// ----------------------------------------------------------------
	// input capture
	// ----------------------------------------------------------------
	logic [3:0] cmd_q;
	logic en_q;
	logic [1:0] bank_q;
	logic [row_w-1:0] addr_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd_q <= cmd_nop;
			en_q <= 1'b0;
			bank_q <= 2'h0;
			addr_q <= '0;
		end else begin
			cmd_q <= link.cmd;
			en_q <= link.clk_en;
			bank_q <= {link.bank_sel_hi, link.bank_sel_lo};
			addr_q <= link.row_col_lines;
		end
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// a high cs_b masks the command regardless of the other lines
	wire live = en_q && !cmd_q[3];
	wire is_act = live && cmd_q == cmd_active;
	wire is_rd = live && cmd_q == cmd_read;
	wire is_wr = live && cmd_q == cmd_write;
	wire is_pre = live && cmd_q == cmd_precharge;
	wire is_ref = live && cmd_q == cmd_refresh;
	wire is_mrs = live && cmd_q == cmd_mode_load;
	wire ap_bit = addr_q[auto_precharge_pos];
	wire [bank_count-1:0] bank_hot = 4'h1 << bank_q;
	wire [bank_count-1:0] pre_mask = ap_bit ? 4'hf : bank_hot;
	wire all_idle = bank_open == 4'h0;
	wire sel_std = bank_q == bank_sel_mode;
	wire sel_ext = bank_q == bank_sel_ext_mode;
	wire acc_closed = (is_rd || is_wr) && !bank_open[bank_q];
	wire mrs_busy = is_mrs && !all_idle;
	wire [bank_count-1:0] ap_mask = burst_start && burst_auto_precharge ?
		4'h1 << burst_bank : 4'h0;

	// ----------------------------------------------------------------
	// bank rows
	// ----------------------------------------------------------------
	logic [row_w-1:0] open_row_q [bank_count];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_open <= 4'h0;
			for (int i = 0; i < bank_count; i++) begin
				open_row_q[i] <= '0;
			end
		end else begin
			if (is_act) begin
				bank_open <= (bank_open & ~ap_mask) | bank_hot;
				open_row_q[bank_q] <= addr_q;
			end else if (is_pre) begin
				bank_open <= bank_open & ~pre_mask & ~ap_mask;
			end else begin
				// self-timed close once the burst has started
				bank_open <= bank_open & ~ap_mask;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_reg <= mode_reset_val;
			ext_mode_reg <= mode_reset_val;
		end else if (is_mrs && all_idle) begin
			if (sel_std) begin
				mode_reg <= addr_q;
			end
			if (sel_ext) begin
				ext_mode_reg <= addr_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// misuse watch: command spacing and mode load before use
	// ----------------------------------------------------------------
	// a spacing or order fault is only reported and the command still takes
	// effect; a mode load with a bank open or an access to a closed bank is dropped
	localparam logic [1:0] mrd_gap = 2'(mode_load_delay_cycles);
	localparam logic [1:0] ref_gap = 2'(refresh_gap_cycles);
	logic [1:0] gap_q;
	logic mode_set_q;
	wire is_op = is_act || is_rd || is_wr;
	wire quiet_cmd = !live || cmd_q == cmd_nop;
	wire gap_fault = !quiet_cmd && gap_q != 2'h0;
	wire order_fault = is_op && !mode_set_q;
	wire [1:0] gap_d = is_ref ? ref_gap : is_mrs ? mrd_gap :
		gap_q != 2'h0 ? gap_q - 2'h1 : 2'h0;
	wire misuse = acc_closed || mrs_busy || gap_fault || order_fault;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gap_q <= 2'h0;
			mode_set_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			if (is_mrs && all_idle && sel_std) begin
				mode_set_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// burst start and misuse flag
	// ----------------------------------------------------------------
	// ordering and length are left to the data path fed by mode_reg
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			burst_start <= 1'b0;
			burst_write <= 1'b0;
			burst_bank <= 2'h0;
			burst_row <= '0;
			burst_col <= '0;
			burst_auto_precharge <= 1'b0;
			bad_cmd <= 1'b0;
		end else begin
			burst_start <= (is_rd || is_wr) && !acc_closed;
			bad_cmd <= misuse;
			if (is_rd || is_wr) begin
				burst_write <= is_wr;
				burst_bank <= bank_q;
				burst_row <= open_row_q[bank_q];
				burst_col <= addr_q[col_w-1:0];
				burst_auto_precharge <= ap_bit;
			end
		end
	end
endmodule

// ==== hdl/sdram_pkg.sv ====
// shared constants and types for the sdram command link
package sdram_pkg;
	localparam int unsigned clk_mhz = 25;
	localparam int unsigned startup_wait_us = 100;
	localparam int unsigned startup_cycles = startup_wait_us * clk_mhz;
	localparam int unsigned refresh_gap_cycles = 3;
	localparam int unsigned mode_load_delay_cycles = 2;
	localparam int unsigned precharge_gap_cycles = 1;
	localparam int unsigned row_w = 12;
	localparam int unsigned col_w = 9;
	localparam int unsigned data_w = 16;
	localparam int unsigned auto_precharge_pos = 10;
	localparam int unsigned bank_count = 4;
	localparam logic [1:0] bank_sel_mode = 2'h0;
	localparam logic [1:0] bank_sel_ext_mode = 2'h2;
	localparam logic [11:0] mode_reset_val = 12'h000;
	localparam logic [11:0] mode_init_val = 12'h023;

	// {cs_b, ras_b, cas_b, we_b}
	typedef enum logic [3:0] {
		cmd_inhibit = 4'h8,
		cmd_nop = 4'h7,
		cmd_active = 4'h3,
		cmd_read = 4'h5,
		cmd_write = 4'h4,
		cmd_precharge = 4'h2,
		cmd_refresh = 4'h1,
		cmd_mode_load = 4'h0
	} cmd_t;
endpackage

// ==== hdl/sdram_link_if.sv ====
// command and address link between controller and memory
`timescale 1ns/1ps
interface sdram_link_if;
	import sdram_pkg::*;
	logic [3:0] cmd;
	logic clk_en;
	logic bank_sel_lo;
	logic bank_sel_hi;
	logic [row_w-1:0] row_col_lines;
	modport host (output cmd, output clk_en, output bank_sel_lo,
		output bank_sel_hi, output row_col_lines);
	modport device (input cmd, input clk_en, input bank_sel_lo,
		input bank_sel_hi, input row_col_lines);
endinterface

// ==== hdl/sdram_init_host.sv ====
// controller end: power-up sequence, then pass-through of user commands
`timescale 1ns/1ps
module sdram_init_host
(
	input wire logic clk,
	input wire logic rst_b,
	sdram_link_if.host link,
	input wire logic [3:0] user_cmd,
	input wire logic [1:0] user_bank,
	input wire logic [sdram_pkg::row_w-1:0] user_addr,
	input wire logic user_valid,
	output logic init_done,
	output logic user_ready
);
	import sdram_pkg::*;

	typedef enum logic [2:0] {
		st_wait = 3'h0,
		st_pre = 3'h1,
		st_ref1 = 3'h2,
		st_ref2 = 3'h3,
		st_mrs = 3'h4,
		st_ext = 3'h5,
		st_run = 3'h6
	} init_st_t;

	init_st_t state_q, state_d;
	logic [15:0] cnt_q;
	logic [3:0] cmd_d;
	logic [1:0] bank_d;
	logic [row_w-1:0] addr_d;
	wire cnt_zero = cnt_q == 16'h0000;
	// start-up count is exact cycles, so the wait is never shortened
	localparam logic [15:0] wait_load = 16'(startup_cycles);
	localparam logic [15:0] ref_load = 16'(refresh_gap_cycles);
	localparam logic [15:0] mrd_load = 16'(mode_load_delay_cycles);
	localparam logic [15:0] pre_load = 16'(precharge_gap_cycles);

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_nop;
		bank_d = 2'h0;
		addr_d = '0;
		if (cnt_zero) begin
			case (state_q)
				st_wait: begin
					state_d = st_pre;
					cmd_d = cmd_precharge;
					addr_d[auto_precharge_pos] = 1'b1;
				end
				st_pre: begin
					state_d = st_ref1;
					cmd_d = cmd_refresh;
				end
				st_ref1: begin
					state_d = st_ref2;
					cmd_d = cmd_refresh;
				end
				st_ref2: begin
					state_d = st_mrs;
					cmd_d = cmd_mode_load;
					bank_d = bank_sel_mode;
					addr_d = mode_init_val;
				end
				st_mrs: begin
					state_d = st_ext;
					cmd_d = cmd_mode_load;
					bank_d = bank_sel_ext_mode;
					addr_d = mode_reset_val;
				end
				st_ext: begin
					state_d = st_run;
				end
				st_run: begin
					if (user_valid) begin
						cmd_d = user_cmd;
						bank_d = user_bank;
						addr_d = user_addr;
					end
				end
				default: begin
					state_d = st_wait;
				end
			endcase
		end
	end

	wire [15:0] cnt_load = state_q == st_wait ? pre_load :
		(state_q == st_pre || state_q == st_ref1) ? ref_load :
		(state_q == st_ref2 || state_q == st_mrs) ? mrd_load : 16'h0000;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= st_wait;
			cnt_q <= wait_load;
		end else begin
			state_q <= state_d;
			if (!cnt_zero) begin
				cnt_q <= cnt_q - 16'h0001;
			end else if (state_q != st_run) begin
				cnt_q <= cnt_load;
			end
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link.cmd <= cmd_nop;
			link.clk_en <= 1'b1;
			link.bank_sel_lo <= 1'b0;
			link.bank_sel_hi <= 1'b0;
			link.row_col_lines <= '0;
			init_done <= 1'b0;
			user_ready <= 1'b0;
		end else begin
			link.cmd <= cmd_d;
			link.clk_en <= 1'b1;
			link.bank_sel_lo <= bank_d[0];
			link.bank_sel_hi <= bank_d[1];
			link.row_col_lines <= addr_d;
			init_done <= state_d == st_run;
			user_ready <= state_d == st_run;
		end
	end
endmodule

// ==== dv/sdram_link_assertions.sv ====
// assertions on the command link between host and memory ends
`timescale 1ns/1ps
module sdram_link_assertions
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] cmd,
	input wire logic clk_en,
	input wire logic bank_sel_lo,
	input wire logic bank_sel_hi,
	input wire logic [sdram_pkg::row_w-1:0] row_col_lines
);
	import sdram_pkg::*;
	localparam int quiet_span = startup_cycles - 1;
	logic [12:0] age_q;
	logic [1:0] refs_q;
	logic opened_q;
	wire quiet = cmd == cmd_nop || cmd == cmd_inhibit;
	wire [1:0] bsel = {bank_sel_hi, bank_sel_lo};
	wire mload = cmd == cmd_mode_load;
	// ------------------------------------------------------------
	// helper state: age since reset, refreshes seen, first command
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			age_q <= '0;
			refs_q <= '0;
			opened_q <= 1'b0;
		end else begin
			// saturate so a long run never wraps back into the wait
			if (age_q != 13'h1fff)
				age_q <= age_q + 13'h1;
			if (cmd == cmd_refresh && refs_q != 2'h2)
				refs_q <= refs_q + 2'h1;
			if (!quiet)
				opened_q <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence two_quiet_s;
		quiet ##1 quiet;
	endsequence
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	wait_quiet_a: assert property (age_q < quiet_span |-> quiet)
		else $error("command issued inside start-up wait");
	first_pre_a: assert property (!opened_q && !quiet |->
		cmd == cmd_precharge && row_col_lines[auto_precharge_pos])
		else $error("first command is not precharge all");
	ref_after_a: assert property (cmd == cmd_refresh |-> opened_q)
		else $error("refresh before banks closed");
	ref_gap_a: assert property (cmd == cmd_refresh |=> two_quiet_s)
		else $error("refresh gap too short");
	two_refs_a: assert property (mload |-> refs_q == 2'h2)
		else $error("mode load before two refreshes");
	mode_gap_a: assert property (mload |=> quiet)
		else $error("mode load delay not kept");
	mode_sel_a: assert property (mload |->
		bsel == bank_sel_mode || bsel == bank_sel_ext_mode)
		else $error("mode load with reserved bank select");
	std_op_a: assert property (mload && bsel == bank_sel_mode |->
		row_col_lines == mode_init_val)
		else $error("standard mode opcode wrong");
	clk_en_a: assert property (clk_en)
		else $error("clock enable dropped");
endmodule

// ==== dv/sdram_cmd_addr_init_bench.sv ====
// self-checking bench for host and memory ends of the command link
`timescale 1ns/1ps
module sdram_cmd_addr_init_bench;
	import sdram_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] ucmd = cmd_nop;
	logic [1:0] ubank = 2'h0;
	logic [11:0] uaddr = 12'h000;
	logic uvalid = 1'b0;
	logic [1:0] rb = 2'h0;
	logic [3:0] open_x = 4'h0;
	logic [11:0] rows [4];
	wire init_done, user_ready, bs_a, bw_a, ap_a, bad_a, bs_b, bad_b;
	wire [3:0] open_a, open_b;
	wire [11:0] mr_a, xr_a, mr_b, xr_b, brow_a;
	wire [1:0] bb_a;
	wire [8:0] bcol_a;
	integer bad_count = 0, checked = 0, seed = 34907, cyc = 0, i;
	sdram_link_if link_a ();
	sdram_link_if link_b ();
	sdram_init_host sdram_init_host_i (.clk(clk), .rst_b(rst_b),
		.link(link_a), .user_cmd(ucmd), .user_bank(ubank),
		.user_addr(uaddr), .user_valid(uvalid), .init_done(init_done),
		.user_ready(user_ready));
	sdram_cmd_dev sdram_cmd_dev_i (.clk(clk), .rst_b(rst_b),
		.link(link_a), .bank_open(open_a), .mode_reg(mr_a),
		.ext_mode_reg(xr_a), .burst_start(bs_a), .burst_write(bw_a),
		.burst_bank(bb_a), .burst_row(brow_a), .burst_col(bcol_a),
		.burst_auto_precharge(ap_a), .bad_cmd(bad_a));
	// second memory end, fed by the bench acting as a faulty controller
	sdram_cmd_dev sdram_cmd_dev_i_b (.clk(clk), .rst_b(rst_b),
		.link(link_b), .bank_open(open_b), .mode_reg(mr_b),
		.ext_mode_reg(xr_b), .burst_start(bs_b), .burst_write(),
		.burst_bank(), .burst_row(), .burst_col(),
		.burst_auto_precharge(), .bad_cmd(bad_b));
	sdram_link_assertions sdram_link_assertions_i (.clk(clk),
		.rst_b(rst_b), .cmd(link_a.cmd), .clk_en(link_a.clk_en),
		.bank_sel_lo(link_a.bank_sel_lo), .bank_sel_hi(link_a.bank_sel_hi),
		.row_col_lines(link_a.row_col_lines));
	// ------------------------------------------------------------
	// clock, timeout, reporting
	// ------------------------------------------------------------
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	task complete_run;
		$display("checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] next_open(input logic [3:0] o,
		input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
		logic [3:0] m;
		m = 4'h1 << b;
		if (c == cmd_active)
			return o | m;
		if (c == cmd_precharge)
			return a[10] ? 4'h0 : o & ~m;
		if ((c == cmd_read || c == cmd_write) && a[10])
			return o & ~m;
		return o;
	endfunction
	// one user command through the host; results show three edges on
	task host_op(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a);
		@(posedge clk);
		ucmd <= c;
		ubank <= b;
		uaddr <= a;
		uvalid <= 1'b1;
		@(posedge clk);
		uvalid <= 1'b0;
		uaddr <= ~a;
		repeat (2) @(posedge clk);
		#1;
		if (c == cmd_active)
			rows[b] = a;
		open_x = next_open(open_x, c, b, a);
		chk(32'({bs_a, bad_a}),
			32'({c == cmd_read || c == cmd_write, 1'b0}));
		if (c == cmd_read || c == cmd_write) begin
			chk(32'({bs_a, bw_a, ap_a, bb_a}),
				32'({1'b1, c == cmd_write, a[10], b}));
			chk(32'({brow_a, bcol_a}), 32'({rows[b], a[8:0]}));
		end
		// an auto-precharge closes the bank one edge after burst_start
		@(posedge clk);
		#1;
		chk(32'(open_a), 32'(open_x));
	endtask
	// raw command on the second link; released lines show inverted data
	task raw_op(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] eo, input logic ebad,
		input logic [11:0] emr, input logic [11:0] exr);
		@(posedge clk);
		link_b.cmd <= c;
		{link_b.bank_sel_hi, link_b.bank_sel_lo} <= b;
		link_b.row_col_lines <= a;
		@(posedge clk);
		link_b.cmd <= cmd_nop;
		link_b.row_col_lines <= ~a;
		@(posedge clk);
		#1;
		chk(32'({bs_b, open_b, bad_b, mr_b, xr_b}),
			32'({1'b0, eo, ebad, emr, exr}));
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		link_b.cmd = cmd_nop;
		link_b.clk_en = 1'b1;
		{link_b.bank_sel_hi, link_b.bank_sel_lo} = 2'h0;
		link_b.row_col_lines = 12'h000;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		wait (init_done === 1'b1);
		#1;
		chk(32'(cyc >= startup_cycles), 32'h1);
		chk(32'({user_ready, open_a, mr_a, xr_a}),
			32'({1'b1, 4'h0, mode_init_val, 12'h000}));
		$display("test init done");
		for (i = 0; i < 24; i = i + 1) begin
			rb = 2'($random(seed));
			if (!open_x[rb])
				host_op(cmd_active, rb, 12'($random(seed)));
			host_op(i[0] ? cmd_write : cmd_read, rb,
				12'($random(seed)) & 12'h5ff);
		end
		host_op(cmd_active, 2'h0, 12'hfff);
		host_op(cmd_read, 2'h0, 12'h5ff);
		host_op(cmd_active, 2'h3, 12'h000);
		host_op(cmd_precharge, 2'h3, 12'h000);
		host_op(cmd_active, 2'h1, 12'h800);
		host_op(cmd_precharge, 2'h2, 12'h400);
		$display("test access done");
		raw_op(cmd_read, 2'h1, 12'h005, 4'h0, 1'b1, 12'h0, 12'h0);
		raw_op(4'hb, 2'h0, 12'h000, 4'h0, 1'b0, 12'h0, 12'h0);
		raw_op(cmd_active, 2'h2, 12'h123, 4'h4, 1'b1, 12'h0, 12'h0);
		raw_op(cmd_precharge, 2'h2, 12'h000, 4'h0, 1'b0, 12'h0, 12'h0);
		raw_op(cmd_mode_load, 2'h2, 12'h5a5, 4'h0, 1'b0, 12'h0, 12'h5a5);
		raw_op(cmd_mode_load, 2'h1, 12'h3c3, 4'h0, 1'b0, 12'h0, 12'h5a5);
		raw_op(cmd_mode_load, 2'h0, 12'h0f0, 4'h0, 1'b0, 12'h0f0, 12'h5a5);
		raw_op(cmd_active, 2'h3, 12'hfff, 4'h8, 1'b0, 12'h0f0, 12'h5a5);
		raw_op(cmd_mode_load, 2'h0, 12'h111, 4'h8, 1'b1, 12'h0f0, 12'h5a5);
		raw_op(cmd_refresh, 2'h0, 12'h000, 4'h8, 1'b0, 12'h0f0, 12'h5a5);
		raw_op(cmd_precharge, 2'h3, 12'h000, 4'h0, 1'b1, 12'h0f0, 12'h5a5);
		$display("test fault link done");
		complete_run;
	end
endmodule
